// ==== src/sldc_consts.vh ====
// Constants for the segment display drive controller
// What this block and its software do
// [R1] Mode register clears to zero on reset: display off, amplifier off, ground, four slots.
// [R2] Mode bit 7 set turns the display on; clear turns it off.
// [R3] Mode bit 6 enables the voltage amplifier; clear means normal operation.
// [R4] Mode bit 4 clear grounds all lines; set gives deselect segments, waveform commons.
// [R5] Mode bit 0 clear selects four slots, set selects three, both 1/3 bias.
// [R6] Software writes zero to mode bits 1, 2, 3 and 5.
// [R7] Amplifier shutdown order: display off, then ground outputs, then amplifier off.
// [R8] Software never clears the amplifier enable while the display is on.
// [R9] Turn on: amplifier on, wait 500 ms, output control on, display on.
// [R10] Clock register clears to zero: subsystem source, post-divider 64.
// [R11] Clock bits 3:2 pick subsystem clock or main clock over 32, 64, 128.
// [R12] Clock bits 1:0 divide the source by 2^6, 2^7, 2^8 or 2^9.
// [R13] Software writes zero to clock register bits 4 to 7.
// [R14] Software changes the clock register only while the amplifier is off.
// [R15] Software keeps the frame frequency at 128 Hz or below.
// [R16] Software picks a source clock of at least 32 kHz.
// [R17] Frame frequency equals the panel clock divided by the slot count.
// [R18] Segment and common drive come from display memory without processor help.
// [R19] Fifteen segments (five on the small variant), four commons, three used in three-slot.
// [R20] Slot n reads bit n of each segment byte; 1 select, 0 deselect.
// [R21] One display byte per segment from FA00H upward; bytes past the last segment are not stored and read zero.
// [R22] Line levels leave as digital select/deselect codes plus a frame polarity.
`ifndef SLDC_CONSTS_VH
`define SLDC_CONSTS_VH

`define SLDC_ADDR_MODE     16'hFFB0
`define SLDC_ADDR_CLOCK    16'hFFB2
`define SLDC_ADDR_MEM_BASE 16'hFA00
`define SLDC_MEM_BYTES     16
`define SLDC_ADDR_MEM_LAST 16'hFA0F

`define SLDC_MODE_RESET    8'h00
`define SLDC_CLOCK_RESET   8'h00
`define SLDC_MODE_MASK     8'hD1
`define SLDC_CLOCK_MASK    8'h0F
`define SLDC_MEM_MASK      8'h0F

`define SLDC_BIT_DISP_EN   7
`define SLDC_BIT_AMP_EN    6
`define SLDC_BIT_OUT_LVL   4
`define SLDC_BIT_SLOT_SEL  0

`define SLDC_SRC_SUB       2'h0
`define SLDC_MAIN_DIV_LOG  4'h5
`define SLDC_POST_DIV_LOG  4'h6

`define SLDC_SLOTS_FOUR    2'h3
`define SLDC_SLOTS_THREE   2'h2

`endif

// ==== src/sldc_drive.v ====
// Segment display drive controller: registers, display memory, dividers, scan
`timescale 1ns/1ps
`include "sldc_consts.vh"

module sldc_drive #(
   parameter NSEG = 15
) (
   input  wire             sys_clk_i,
   input  wire             rst_i,
   input  wire [15:0]      addr_i,
   input  wire [7:0]       wdata_i,
   input  wire             wr_i,
   input  wire             rd_i,
   output wire [7:0]       rdata_o,
   input  wire             sub_clk_i,
   input  wire             main_clk_i,
   output wire             amp_en_o,
   output wire             drive_on_o,
   output wire [3:0]       com_sel_o,
   output wire [NSEG-1:0]  seg_sel_o,
   output wire             polarity_o,
   output wire [1:0]       slot_o,
   output wire             panel_clock_o
);

   // Low n bits of a counter all ones
   function low_ones;
      input [8:0] val;
      input [3:0] n;
      integer k;
      begin
         low_ones = 1'b1;
         for (k = 0; k < 9; k = k + 1) begin
            if (k < n && !val[k])
               low_ones = 1'b0;
         end
      end
   endfunction

   reg  [7:0]      mode_reg;
   reg  [7:0]      clock_reg;
   reg  [7:0]      rdata_reg;
   reg  [3:0]      mem [0:`SLDC_MEM_BYTES-1];
   reg             sub_d_reg;
   reg             main_d_reg;
   reg  [6:0]      main_cnt_reg;
   reg  [8:0]      post_cnt_reg;
   reg  [1:0]      slot_reg;
   reg             polarity_reg;
   reg             panel_clock_reg;
   reg  [3:0]      com_sel_reg;
   reg  [NSEG-1:0] seg_sel_reg;
   reg             drive_on_reg;
   reg  [7:0]      rdata_next;
   reg  [NSEG-1:0] seg_next;
   reg  [3:0]      com_next;
   reg             src_tick;
   integer         i;

   wire        disp_en  = mode_reg[`SLDC_BIT_DISP_EN];
   wire        amp_en   = mode_reg[`SLDC_BIT_AMP_EN];
   wire        out_lvl  = mode_reg[`SLDC_BIT_OUT_LVL];
   wire        three    = mode_reg[`SLDC_BIT_SLOT_SEL];
   wire [1:0]  src_sel  = clock_reg[3:2];
   wire [1:0]  post_sel = clock_reg[1:0];
   wire        sub_rise  = sub_clk_i & ~sub_d_reg;
   wire        main_rise = main_clk_i & ~main_d_reg;
   wire        mem_hit   = (addr_i >= `SLDC_ADDR_MEM_BASE) &&
                           (addr_i < `SLDC_ADDR_MEM_BASE + NSEG);
   wire [3:0]  mem_idx   = addr_i[3:0];
   // [R5] last slot index
   wire [1:0]  last_slot = three ? `SLDC_SLOTS_THREE : `SLDC_SLOTS_FOUR;
   // [R12] panel clock from post-divider
   wire        lcd_tick  = src_tick &&
                           low_ones(post_cnt_reg, `SLDC_POST_DIV_LOG + {2'h0, post_sel});

   // [R11] source clock selection
   always @* begin
      if (src_sel == `SLDC_SRC_SUB)
         src_tick = sub_rise;
      else
         src_tick = main_rise &&
                    low_ones({2'h0, main_cnt_reg}, `SLDC_MAIN_DIV_LOG - 4'h1 + {2'h0, src_sel});
   end

   // [R1] mode register, unused bits kept zero
   always @(posedge sys_clk_i or posedge rst_i) begin
      if (rst_i) begin
         mode_reg <= `SLDC_MODE_RESET;
      end else if (wr_i && addr_i == `SLDC_ADDR_MODE) begin
         mode_reg <= wdata_i & `SLDC_MODE_MASK;
      end
   end

   // [R10] clock register
   always @(posedge sys_clk_i or posedge rst_i) begin
      if (rst_i) begin
         clock_reg <= `SLDC_CLOCK_RESET;
      end else if (wr_i && addr_i == `SLDC_ADDR_CLOCK) begin
         clock_reg <= wdata_i & `SLDC_CLOCK_MASK;
      end
   end

   // [R21] display memory, high nibble not stored
   always @(posedge sys_clk_i) begin
      if (wr_i && mem_hit)
         mem[mem_idx] <= wdata_i[3:0];
   end

   always @* begin
      rdata_next = 8'h00;
      if (addr_i == `SLDC_ADDR_MODE)
         rdata_next = mode_reg;
      else if (addr_i == `SLDC_ADDR_CLOCK)
         rdata_next = clock_reg;
      else if (mem_hit)
         rdata_next = {4'h0, mem[mem_idx]};
   end

   always @(posedge sys_clk_i or posedge rst_i) begin
      if (rst_i) begin
         rdata_reg <= 8'h00;
      end else if (rd_i) begin
         rdata_reg <= rdata_next;
      end else begin
         rdata_reg <= 8'h00;
      end
   end

   // Clock pins sampled as plain levels
   always @(posedge sys_clk_i or posedge rst_i) begin
      if (rst_i) begin
         sub_d_reg    <= 1'b0;
         main_d_reg   <= 1'b0;
         main_cnt_reg <= 7'h00;
      end else begin
         sub_d_reg  <= sub_clk_i;
         main_d_reg <= main_clk_i;
         if (main_rise)
            main_cnt_reg <= main_cnt_reg + 7'h01;
      end
   end

   // [R17] one slot per panel clock, frame ends at last slot
   always @(posedge sys_clk_i or posedge rst_i) begin
      if (rst_i) begin
         post_cnt_reg    <= 9'h000;
         slot_reg        <= 2'h0;
         polarity_reg    <= 1'b0;
         panel_clock_reg <= 1'b0;
      end else begin
         panel_clock_reg <= lcd_tick;
         if (src_tick)
            post_cnt_reg <= post_cnt_reg + 9'h001;
         if (!out_lvl) begin
            slot_reg     <= 2'h0;
            polarity_reg <= 1'b0;
         end else if (lcd_tick) begin
            if (slot_reg >= last_slot) begin
               slot_reg     <= 2'h0;
               polarity_reg <= ~polarity_reg;
            end else begin
               slot_reg <= slot_reg + 2'h1;
            end
         end
      end
   end

   // [R20] slot n picks bit n of each byte
   always @* begin
      seg_next = {NSEG{1'b0}};
      com_next = 4'h0;
      // [R4] ground when output control clear
      if (out_lvl) begin
         com_next = 4'h1 << slot_reg;
         // [R19] fourth common idle in three-slot mode
         if (three)
            com_next[3] = 1'b0;
         // [R2] segments follow memory only when display on
         if (disp_en) begin
            for (i = 0; i < NSEG; i = i + 1)
               seg_next[i] = mem[i][slot_reg];
         end
      end
   end

   // [R18] automatic scan outputs
   always @(posedge sys_clk_i or posedge rst_i) begin
      if (rst_i) begin
         com_sel_reg  <= 4'h0;
         seg_sel_reg  <= {NSEG{1'b0}};
         drive_on_reg <= 1'b0;
      end else begin
         com_sel_reg  <= com_next;
         seg_sel_reg  <= seg_next;
         drive_on_reg <= out_lvl;
      end
   end

   assign rdata_o       = rdata_reg;
   // [R3] amplifier enable straight from mode bit
   assign amp_en_o      = amp_en;
   // [R22] digital level codes for analog drivers
   assign drive_on_o    = drive_on_reg;
   assign com_sel_o     = com_sel_reg;
   assign seg_sel_o     = seg_sel_reg;
   assign polarity_o    = polarity_reg;
   assign slot_o        = slot_reg;
   assign panel_clock_o = panel_clock_reg;

endmodule

// ==== tb/sldc_drive_chk.sv ====
// Port assertions for the segment display drive controller
`timescale 1ns/1ps
module sldc_drive_chk #(
   parameter NSEG = 15
) (
   input wire            sys_clk_i,
   input wire            rst_i,
   input wire [15:0]     addr_i,
   input wire [7:0]      wdata_i,
   input wire            wr_i,
   input wire            rd_i,
   input wire [7:0]      rdata_o,
   input wire            amp_en_o,
   input wire            drive_on_o,
   input wire [3:0]      com_sel_o,
   input wire [NSEG-1:0] seg_sel_o,
   input wire            polarity_o,
   input wire [1:0]      slot_o,
   input wire            panel_clock_o
);
   default clocking dc @(posedge sys_clk_i);
   endclocking
   default disable iff (rst_i);
   a_amp_follow: assert property (wr_i && addr_i == 16'hFFB0 |=> amp_en_o == $past(wdata_i[6]))
      else $error("amp enable wrong");
   a_drive_lag: assert property (wr_i && addr_i == 16'hFFB0 |=> ##1 drive_on_o == $past(wdata_i[4], 2))
      else $error("drive level wrong");
   a_ground_idle: assert property (!drive_on_o && !$past(drive_on_o) |-> !com_sel_o && !seg_sel_o && !polarity_o)
      else $error("lines not grounded");
   a_com_onehot: assert property (com_sel_o != 4'h0 |-> $onehot(com_sel_o))
      else $error("commons not one-hot");
   a_mode_read: assert property (rd_i && addr_i == 16'hFFB0 |=> rdata_o[6] == amp_en_o && !(rdata_o & 8'h2E))
      else $error("mode readback wrong");
   a_rdata_idle: assert property (!$past(rd_i) || $past(addr_i) == 16'hFFB1 |-> rdata_o == 8'h00)
      else $error("read data not idle");
   a_pulse_gap: assert property (panel_clock_o |=> !panel_clock_o [*8])
      else $error("panel clock too fast");
   a_slot_step: assert property ($changed(slot_o) && slot_o != 2'h0 |-> slot_o == $past(slot_o) + 2'h1)
      else $error("slot skipped");
endmodule
bind sldc_drive sldc_drive_chk #(.NSEG(NSEG)) i_chk (.*);

// ==== tb/sldc_panel.sv ====
// Passive panel model: keeps the segment image seen under each common
`timescale 1ns/1ps
module sldc_panel #(
   parameter NSEG = 15
) (
   input  wire                  clk_i,
   input  wire [3:0]            com_i,
   input  wire [NSEG-1:0]       seg_i,
   output logic [3:0][NSEG-1:0] lit_o
);
   always @(posedge clk_i)
      for (int c = 0; c < 4; c++)
         if (com_i[c]) lit_o[c] <= seg_i;
endmodule

// ==== tb/sldc_drive_tb.sv ====
// Bench for the segment display drive controller
`timescale 1ns/1ps
module sldc_drive_tb;
   logic             sys_clk_i = 0, rst_i = 1, wr_i = 0, rd_i = 0, sub_clk_i = 0, main_clk_i = 0;
   logic [15:0]      addr_i = 16'h0000;
   logic [7:0]       wdata_i = 8'h00, rdata_o;
   logic             amp_en_o, drive_on_o, polarity_o, panel_clock_o;
   logic [3:0]       com_sel_o;
   logic [14:0]      seg_sel_o;
   logic [1:0]       slot_o;
   logic [3:0][14:0] lit;
   logic [7:0]       codes [4] = '{8'h01, 8'h03, 8'h04, 8'h08};
   int               bad_count = 0, compares = 0, cyc = 0;
   realtime          t;
   sldc_drive #(.NSEG(15)) i_dut (.*);
   sldc_panel #(.NSEG(15)) i_panel (.clk_i(sys_clk_i), .com_i(com_sel_o), .seg_i(seg_sel_o), .lit_o(lit));
   always #12.5 sys_clk_i = ~sys_clk_i;
   // Source clocks rise every two cycles; run is about 50k cycles
   always @(posedge sys_clk_i) begin
      sub_clk_i <= ~sub_clk_i;
      main_clk_i <= ~main_clk_i;
      cyc <= cyc + 1;
      if (cyc == 90000) begin
         bad_count++;
         finish_test;
      end
   end
   task finish_test;
      $display("compares %0d mismatches %0d", compares, bad_count);
      if (bad_count == 0 && compares > 0) $display("Finished cleanly");
      else $display("Finished with errors");
      $finish;
   endtask
   task chk(input string what, input logic [31:0] exp, input logic [31:0] got);
      compares++;
      if (got !== exp) begin
         bad_count++;
         $display("FAIL %s expected %0h seen %0h", what, exp, got);
      end
   endtask
   task wr(input logic [15:0] a, input logic [7:0] d);
      @(posedge sys_clk_i);
      wr_i <= 1'h1;
      addr_i <= a;
      wdata_i <= d;
      @(posedge sys_clk_i);
      wr_i <= 1'h0;
      // Let the write settle before callers look at outputs
      #1;
   endtask
   task rd(input logic [15:0] a, input logic [7:0] exp);
      @(posedge sys_clk_i);
      rd_i <= 1'h1;
      addr_i <= a;
      @(posedge sys_clk_i);
      rd_i <= 1'h0;
      #1 chk("read", exp, rdata_o);
   endtask
   // First span after a change may be short, so skip it
   task per(input int exp);
      @(posedge panel_clock_o);
      @(posedge panel_clock_o);
      t = $realtime;
      @(posedge panel_clock_o);
      chk("panel period", exp, int'(($realtime - t) / 25.0));
   endtask
   task frame(input int exp);
      @(polarity_o);
      @(polarity_o);
      t = $realtime;
      @(polarity_o);
      chk("frame length", exp, int'(($realtime - t) / 25.0));
   endtask
   task image(input logic on);
      logic [14:0] e;
      @(polarity_o);
      @(polarity_o);
      for (int c = 0; c < 4; c++) begin
         for (int i = 0; i < 15; i++)
            e[i] = on & ((i + 1) >> c);
         chk("pixels", e, lit[c]);
      end
   endtask
   initial begin
      repeat (4) @(posedge sys_clk_i);
      rst_i <= 1'h0;
      rd(16'hFFB0, 8'h00);
      rd(16'hFFB2, 8'h00);
      $display("test reset done");
      wr(16'hFFB2, 8'h0F);
      rd(16'hFFB2, 8'h0F);
      wr(16'hFFB2, 8'h01);
      wr(16'hFFB1, 8'h5A);
      rd(16'hFFB1, 8'h00);
      for (int i = 0; i < 15; i++)
         wr(16'hFA00 + 16'(i), 8'(i + 1));
      rd(16'hFA0E, 8'h0F);
      rd(16'hFA0F, 8'h00);
      $display("test registers done");
      wr(16'hFFB0, 8'h40);
      chk("amp", 1, amp_en_o);
      wr(16'hFFB0, 8'h50);
      wr(16'hFFB0, 8'hD0);
      rd(16'hFFB0, 8'hD0);
      chk("drive", 1, drive_on_o);
      image(1'h1);
      per(256);
      frame(1024);
      wr(16'hFFB0, 8'hD1);
      frame(768);
      wr(16'hFFB0, 8'h50);
      image(1'h0);
      wr(16'hFFB0, 8'h40);
      wr(16'hFFB0, 8'h00);
      rd(16'hFFB0, 8'h00);
      chk("amp", 0, amp_en_o);
      $display("test scan done");
      wr(16'hFFB0, 8'h10);
      foreach (codes[j]) begin
         wr(16'hFFB2, codes[j]);
         per((codes[j][3:2] == 2'h0 ? 2 : 2 << (4 + codes[j][3:2])) << (6 + codes[j][1:0]));
      end
      $display("test clocks done");
      finish_test;
   end
endmodule
